// [rtl/acr_map.vh]
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
// Register offsets
`define ACR_OFS_PORT_CFG 13'h000
`define ACR_OFS_CHIP_IDENTIFIER 13'h001
`define ACR_OFS_GRADE 13'h002
`define ACR_OFS_SEL_HIGH 13'h004
`define ACR_OFS_SEL_LOW 13'h005
`define ACR_OFS_COMMIT 13'h0ff
// Port configuration fields
`define ACR_PC_LSB_A 6
`define ACR_PC_LSB_B 1
`define ACR_PC_RST_A 5
`define ACR_PC_RST_B 2
`define ACR_PC_RST_VAL 8'h18
// Speed grade field
`define ACR_GRADE_HI 5
`define ACR_GRADE_LO 4
`define ACR_GRADE_RST 2'h0
`define ACR_GRADE_40 2'h0
`define ACR_GRADE_65 2'h1
`define ACR_GRADE_80 2'h2
`define ACR_GRADE_125 2'h3
// Index register defaults
`define ACR_SEL_HIGH_RST 4'hf
`define ACR_SEL_LOW_RST 6'h3f
// Identifier, arbitrary neutral value
`define ACR_CHIP_IDENTIFIER_VAL 8'h5a
// Frame layout
`define ACR_HDR_BITS 5'd16
`define ACR_HDR_READ 15
`endif

// [rtl/acr_chip_cfg.v]
// Operation
// R01 - Mirrored port config, bit order, reset, 0x18
// R02 - Soft reset restores all other registers
// R03 - Reset request bits self-clear after reset
// R04 - Read-only fixed chip identifier byte
// R05 - Speed grade bits 5:4 select rate
// R06 - Host commits grade via update register
// R07 - Any update write triggers, reads zero
// R08 - Update reloads analog defaults only
// R09 - Update acts only after grade write
// R10 - High index selects channels H..E
// R11 - Low index selects clocks, channels D..A
// R12 - Writes go only to selected lanes
// R13 - Local writes indexed, chip writes mode-gated
// R14 - Device reset loads defaults
// R15 - Host writes only documented defaults
// R16 - Grade-written flag qualifies update
`include "acr_map.vh"
`default_nettype none
module acr_chip_cfg
(
   input wire mclk,
   input wire rst,
   input wire sclk,
   input wire csb_n,
   input wire sdio_in,
   output wire sdio_out,
   output wire sdio_oe,
   input wire ext_is_local,
   input wire chip_selected,
   output reg [1:0] speed_mode_r,
   output reg commit_pulse_r,
   output reg soft_reset_pulse_r,
   output reg ext_wr_stb_r,
   output reg [12:0] ext_wr_addr_r,
   output reg [7:0] ext_wr_data_r,
   output wire [7:0] ext_chan_mask,
   output wire [1:0] ext_clk_mask,
   output wire lsb_first
);
   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   reg [1:0] sclk_s_r;
   reg [1:0] csb_s_r;
   reg [1:0] sdi_s_r;
   reg sclk_d_r;
   always @(posedge mclk)
   begin
      if (rst)
      begin
         sclk_s_r <= 2'h0;
         csb_s_r <= 2'h3;
         sdi_s_r <= 2'h0;
         sclk_d_r <= 1'b0;
      end
      else
      begin
         sclk_s_r <= {sclk_s_r[0], sclk};
         csb_s_r <= {csb_s_r[0], csb_n};
         sdi_s_r <= {sdi_s_r[0], sdio_in};
         sclk_d_r <= sclk_s_r[1];
      end
   end
   wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
   wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
   wire active = ~csb_s_r[1];
   // Edges show two or three cycles late; half periods need four

   // ==========================================================
   // Register state
   // ==========================================================
   reg lsb_r;
   reg [1:0] grade_r;
   reg [3:0] sel_high_r;
   reg [5:0] sel_low_r;
   reg grade_wr_r;
   assign lsb_first = lsb_r;
   assign ext_chan_mask = {sel_high_r, sel_low_r[3:0]}; // R10 R11
   assign ext_clk_mask = sel_low_r[5:4]; // R11

   // ==========================================================
   // Frame state
   // ==========================================================
   reg [4:0] hdr_cnt_r;
   reg [2:0] bit_cnt_r;
   reg [15:0] shift_r;
   reg is_read_r;
   reg [12:0] addr_r;
   reg dout_r;
   reg oe_r;
   wire in_data = (hdr_cnt_r == `ACR_HDR_BITS);
   wire [15:0] shift_nxt = {shift_r[14:0], sdi_s_r[1]};
   reg [15:0] hdr_nxt;
   reg [7:0] byte_nxt;
   reg [7:0] rd_data;
   integer i;
   always @*
   begin
      hdr_nxt = shift_nxt;
      byte_nxt = shift_nxt[7:0];
      if (lsb_r)
      begin
         for (i = 0; i < 16; i = i + 1)
            hdr_nxt[i] = shift_nxt[15 - i];
         for (i = 0; i < 8; i = i + 1)
            byte_nxt[i] = shift_nxt[7 - i];
      end
   end

   // ==========================================================
   // Read mux
   // ==========================================================
   // Reset request bits are never stored, so they always read cleared
   wire [7:0] pc_rd = `ACR_PC_RST_VAL | ({7'h0, lsb_r} << `ACR_PC_LSB_A) |
      ({7'h0, lsb_r} << `ACR_PC_LSB_B); // R03
   always @*
   begin
      case (addr_r)
         `ACR_OFS_PORT_CFG:
            rd_data = pc_rd; // R01 R03
         `ACR_OFS_CHIP_IDENTIFIER:
            rd_data = `ACR_CHIP_IDENTIFIER_VAL; // R04
         `ACR_OFS_GRADE:
            rd_data = {2'h0, grade_r, 4'h0}; // R05
         `ACR_OFS_SEL_HIGH:
            rd_data = {4'h0, sel_high_r};
         `ACR_OFS_SEL_LOW:
            rd_data = {2'h0, sel_low_r};
         default:
            rd_data = 8'h00; // R07
      endcase
   end
   wire [2:0] out_idx = lsb_r ? bit_cnt_r : (3'h7 - bit_cnt_r);
   assign sdio_out = dout_r;
   assign sdio_oe = oe_r;

   // ==========================================================
   // Serial engine and register writes
   // ==========================================================
   wire byte_done = sclk_rise & active & in_data & (bit_cnt_r == 3'h7);
   wire wr_now = byte_done & ~is_read_r;
   wire [12:0] addr_step = lsb_r ? addr_r + 13'h1 : addr_r - 13'h1;

   // ==========================================================
   // Address decode
   // ==========================================================
   wire hit_pc = (addr_r == `ACR_OFS_PORT_CFG);
   wire hit_id = (addr_r == `ACR_OFS_CHIP_IDENTIFIER);
   wire hit_grade = (addr_r == `ACR_OFS_GRADE);
   wire hit_high = (addr_r == `ACR_OFS_SEL_HIGH);
   wire hit_low = (addr_r == `ACR_OFS_SEL_LOW);
   wire hit_commit = (addr_r == `ACR_OFS_COMMIT);
   wire hit_bank = hit_pc | hit_id | hit_grade | hit_high | hit_low |
      hit_commit;
   wire wr_pc = wr_now & hit_pc;
   // Either mirrored copy counts, so the byte works in both bit orders
   wire lsb_req = byte_nxt[`ACR_PC_LSB_A] | byte_nxt[`ACR_PC_LSB_B]; // R01
   wire soft_rst = wr_pc &
      (byte_nxt[`ACR_PC_RST_A] | byte_nxt[`ACR_PC_RST_B]); // R01
   wire wr_grade = wr_now & hit_grade;
   wire wr_high = wr_now & hit_high;
   wire wr_low = wr_now & hit_low;
   // Anything outside this bank goes out with the lane masks
   wire wr_ext = wr_now & ~hit_bank;
   // Value of the byte is ignored, only the strobe matters
   wire do_commit = wr_now & hit_commit & grade_wr_r; // R07 R09

   // ==========================================================
   // Frame shift and read drive
   // ==========================================================
   always @(posedge mclk)
   begin
      if (rst)
      begin
         hdr_cnt_r <= 5'h0;
         bit_cnt_r <= 3'h0;
         shift_r <= 16'h0;
         is_read_r <= 1'b0;
         addr_r <= 13'h0;
         dout_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else if (!active)
      begin
         hdr_cnt_r <= 5'h0;
         bit_cnt_r <= 3'h0;
         oe_r <= 1'b0;
      end
      else
      begin
         if (sclk_rise)
         begin
            shift_r <= shift_nxt;
            if (!in_data)
            begin
               hdr_cnt_r <= hdr_cnt_r + 5'h1;
               if (hdr_cnt_r == `ACR_HDR_BITS - 5'h1)
               begin
                  is_read_r <= hdr_nxt[`ACR_HDR_READ];
                  addr_r <= hdr_nxt[12:0];
               end
            end
            else
            begin
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (bit_cnt_r == 3'h7)
                  addr_r <= addr_step;
            end
         end
         // Drive on falling edge so data is stable at the next rise
         if (sclk_fall && in_data && is_read_r)
         begin
            dout_r <= rd_data[out_idx];
            oe_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Port configuration
   // ==========================================================
   // Kept apart: a soft reset must not undo the order just written
   always @(posedge mclk)
   begin
      if (rst)
         lsb_r <= 1'b0; // R14
      else if (wr_pc)
         lsb_r <= lsb_req; // R01 R02
   end

   // ==========================================================
   // Speed grade and commit
   // ==========================================================
   always @(posedge mclk)
   begin
      if (rst)
      begin
         grade_r <= `ACR_GRADE_RST; // R14
         grade_wr_r <= 1'b0;
         speed_mode_r <= `ACR_GRADE_RST;
      end
      else if (soft_rst)
      begin
         grade_r <= `ACR_GRADE_RST; // R02
         grade_wr_r <= 1'b0; // R16
         speed_mode_r <= `ACR_GRADE_RST;
      end
      else
      begin
         if (wr_grade)
            grade_r <= byte_nxt[`ACR_GRADE_HI:`ACR_GRADE_LO]; // R05
         // Grade field itself survives the commit
         if (do_commit)
            speed_mode_r <= grade_r; // R06 R08
         if (wr_grade)
            grade_wr_r <= 1'b1; // R16
         else if (do_commit)
            grade_wr_r <= 1'b0; // R16
      end
   end

   // ==========================================================
   // Channel and clock lane index
   // ==========================================================
   always @(posedge mclk)
   begin
      if (rst || soft_rst)
      begin
         sel_high_r <= `ACR_SEL_HIGH_RST; // R02 R14
         sel_low_r <= `ACR_SEL_LOW_RST;
      end
      else
      begin
         if (wr_high)
            sel_high_r <= byte_nxt[3:0]; // R10
         if (wr_low)
            sel_low_r <= byte_nxt[5:0]; // R11
      end
   end

   // ==========================================================
   // Pulses and outside writes
   // ==========================================================
   always @(posedge mclk)
   begin
      if (rst)
      begin
         commit_pulse_r <= 1'b0;
         soft_reset_pulse_r <= 1'b0;
         ext_wr_stb_r <= 1'b0;
         ext_wr_addr_r <= 13'h0;
         ext_wr_data_r <= 8'h00;
      end
      else
      begin
         commit_pulse_r <= do_commit; // R08
         soft_reset_pulse_r <= soft_rst; // R02
         // Local writes follow the index masks, chip writes the chip mode
         ext_wr_stb_r <= wr_ext & (ext_is_local | chip_selected); // R12 R13
         if (wr_ext)
         begin
            ext_wr_addr_r <= addr_r;
            ext_wr_data_r <= byte_nxt;
         end
      end
   end
endmodule // acr_chip_cfg
`default_nettype wire

// [testbench/acr_chip_cfg_props.sv]
`default_nettype none
module acr_chip_cfg_props (
   input wire logic mclk,
   input wire logic rst,
   input wire logic csb_n,
   input wire logic sdio_oe,
   input wire logic ext_is_local,
   input wire logic chip_selected,
   input wire logic [1:0] speed_mode_r,
   input wire logic commit_pulse_r,
   input wire logic soft_reset_pulse_r,
   input wire logic ext_wr_stb_r,
   input wire logic [7:0] ext_chan_mask,
   input wire logic [1:0] ext_clk_mask,
   input wire logic lsb_first
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // ==========
   // Properties
   a_reset_dflt: assert property ($fell(rst) |->
      speed_mode_r == 2'h0 && ext_chan_mask == 8'hff &&
      ext_clk_mask == 2'h3 && !lsb_first && !sdio_oe)
      else $error("defaults missing after reset");
   a_commit_single: assert property (commit_pulse_r |=> !commit_pulse_r)
      else $error("commit pulse too long");
   a_srst_single: assert property (
      soft_reset_pulse_r |=> !soft_reset_pulse_r)
      else $error("soft reset request did not clear");
   a_srst_dflt: assert property (soft_reset_pulse_r |->
      ext_chan_mask == 8'hff && ext_clk_mask == 2'h3 && speed_mode_r == 2'h0)
      else $error("soft reset left a register changed");
   a_mode_cause: assert property ($changed(speed_mode_r) |->
      ##[0:1] (commit_pulse_r || soft_reset_pulse_r))
      else $error("speed mode moved without commit");
   a_ext_gated: assert property (
      ext_wr_stb_r |-> $past(ext_is_local) || $past(chip_selected))
      else $error("outside write not gated");
   a_idle_quiet: assert property (csb_n [*8] |->
      !commit_pulse_r && !ext_wr_stb_r && !sdio_oe)
      else $error("activity outside a frame");
   a_masks_hold: assert property (csb_n [*8] |->
      $stable(ext_chan_mask) && $stable(ext_clk_mask) && $stable(lsb_first))
      else $error("masks moved outside a frame");
endmodule // acr_chip_cfg_props
bind acr_chip_cfg acr_chip_cfg_props u_acr_chip_cfg_props (.mclk, .rst,
   .csb_n, .sdio_oe, .ext_is_local, .chip_selected, .speed_mode_r,
   .commit_pulse_r, .soft_reset_pulse_r, .ext_wr_stb_r, .ext_chan_mask,
   .ext_clk_mask, .lsb_first);
`default_nettype wire

// [testbench/acr_host.sv]
`default_nettype none
module acr_host (
   input wire logic mclk,
   output logic sclk,
   output logic csb_n,
   output logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      sclk = 1'b0;
      csb_n = 1'b1;
      sdio_in = 1'b0;
   end
   // ==========
   // One frame, link clock idles low between frames
   task frame(input logic [15:0] hdr, input logic [7:0] wd,
      output logic [7:0] rd);
      logic [23:0] b;
      b = {hdr, wd};
      @(negedge mclk);
      csb_n = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         // Released line toggles so a stale bit cannot pass
         sdio_in = (hdr[15] && i < 8) ? ~sdio_in : b[i];
         #100 sclk = 1'b1;
         // Undriven line reads inverted so a missing enable shows
         if (i < 8) rd[i] = sdio_oe ? sdio_out : ~sdio_out;
         #100 sclk = 1'b0;
      end
      #100 csb_n = 1'b1;
      sdio_in = ~sdio_in;
      #200;
   endtask
endmodule // acr_host
`default_nettype wire

// [testbench/testbench.sv]
`include "acr_map.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst, sclk, csb_n, sdio_in, sdio_out, sdio_oe, chip_selected;
   logic commit_pulse_r, soft_reset_pulse_r, ext_wr_stb_r, lsb_first;
   logic ext_is_local;
   logic [1:0] speed_mode_r, ext_clk_mask;
   logic [7:0] ext_wr_data_r, ext_chan_mask, v;
   logic [12:0] ext_wr_addr_r;
   int fails, checks_done, n_cmt, n_ext, n_srst, c;
   acr_chip_cfg u_acr_chip_cfg (.mclk, .rst, .sclk, .csb_n, .sdio_in,
      .sdio_out, .sdio_oe, .ext_is_local, .chip_selected,
      .speed_mode_r, .commit_pulse_r, .soft_reset_pulse_r, .ext_wr_stb_r,
      .ext_wr_addr_r, .ext_wr_data_r, .ext_chan_mask, .ext_clk_mask,
      .lsb_first);
   acr_host u_acr_host (.mclk, .sclk, .csb_n, .sdio_in, .sdio_out,
      .sdio_oe);
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      n_cmt <= n_cmt + commit_pulse_r;
      n_ext <= n_ext + ext_wr_stb_r;
      n_srst <= n_srst + soft_reset_pulse_r;
   end
   // ==========
   // Tasks
   task chk(input logic [7:0] g, e);
      checks_done++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task wr(input logic [12:0] a, input logic [7:0] d);
      u_acr_host.frame({3'b000, a}, d, v);
      repeat (6) @(negedge mclk);
   endtask
   task rd(input logic [12:0] a);
      u_acr_host.frame({3'b100, a}, 8'h00, v);
   endtask
   task t_ident;
      rd(`ACR_OFS_CHIP_IDENTIFIER);
      chk(v, `ACR_CHIP_IDENTIFIER_VAL);
      wr(`ACR_OFS_CHIP_IDENTIFIER, 8'h00);
      rd(`ACR_OFS_CHIP_IDENTIFIER);
      chk(v, `ACR_CHIP_IDENTIFIER_VAL);
      rd(`ACR_OFS_PORT_CFG);
      chk(v, 8'h18);
   endtask
   task t_grade;
      c = n_cmt;
      wr(`ACR_OFS_COMMIT, 8'h5c);
      chk(8'(n_cmt - c), 8'h00);
      for (int g = 0; g < 4; g++)
      begin
         wr(`ACR_OFS_GRADE, 8'(g << 4));
         chk({6'h0, speed_mode_r}, 8'(g ? g - 1 : 0));
         wr(`ACR_OFS_COMMIT, 8'(g * 8'h11));
         chk({6'h0, speed_mode_r}, 8'(g));
         rd(`ACR_OFS_GRADE);
         chk(v, 8'(g << 4));
      end
      wr(`ACR_OFS_COMMIT, 8'hff);
      chk(8'(n_cmt - c), 8'h04);
   endtask
   task t_index;
      wr(`ACR_OFS_SEL_HIGH, 8'h05);
      wr(`ACR_OFS_SEL_LOW, 8'h2a);
      chk(ext_chan_mask, 8'h5a);
      chk({6'h0, ext_clk_mask}, 8'h02);
      rd(`ACR_OFS_SEL_LOW);
      chk(v, 8'h2a);
      rd(`ACR_OFS_SEL_HIGH);
      chk(v, 8'h05);
      c = n_ext;
      wr(13'h010, 8'h3c);
      chk(8'(n_ext - c), 8'h00);
      chip_selected = 1'b1;
      wr(13'h010, 8'h3c);
      chk(8'(n_ext - c), 8'h01);
      chk(ext_wr_data_r, 8'h3c);
      chk(ext_wr_addr_r[7:0], 8'h10);
      chip_selected = 1'b0;
      ext_is_local = 1'b1;
      wr(13'h011, 8'hc3);
      chk(8'(n_ext - c), 8'h02);
      chk(ext_wr_data_r, 8'hc3);
      ext_is_local = 1'b0;
   endtask
   task t_port;
      c = n_srst;
      wr(`ACR_OFS_PORT_CFG, 8'h42);
      chk({7'h0, lsb_first}, 8'h01);
      // Header and data both travel reversed in this order
      u_acr_host.frame(16'ha001, 8'h00, v);
      chk(v, 8'h54);
      // Byte and header read the same in either bit order
      wr(`ACR_OFS_PORT_CFG, 8'h24);
      chk(8'(n_srst - c), 8'h01);
      chk({6'h0, speed_mode_r}, 8'h00);
      chk({ext_clk_mask, 6'h0}, 8'hc0);
      chk(ext_chan_mask, 8'hff);
      rd(`ACR_OFS_PORT_CFG);
      chk(v, 8'h18);
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      rst = 1'b1;
      chip_selected = 1'b0;
      ext_is_local = 1'b0;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk({lsb_first, ext_clk_mask, 5'h0}, 8'h60);
      t_ident();
      t_grade();
      t_index();
      t_port();
      wrap_up();
   end
   initial
   begin
      #1ms;
      fails++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
